// *** rtl/boot_strap_mode_select.sv ***
// Boot mode latch, boot window sequencing and post-boot pin setup
`timescale 1ns/1ps
module boot_strap_mode_select
	import boot_strap_pkg::*;
#(
	parameter int unsigned BOOT_COUNT = BOOT_CYCLES
)
(
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	input  wire logic [GPIO_WIDTH-1:0] gpio_in,
	input  wire logic                  clock_source_strap,
	input  wire logic                  usb_load_req,
	input  wire logic                  eeprom_load_done,
	output logic      [1:0]            boot_mode,
	output logic                       clock_is_12mhz,
	output logic                       boot_busy,
	output logic                       boot_done,
	output logic                       parallel_host_port_en,
	output logic                       fast_serial_port_en,
	output logic                       spi_slave_en,
	output logic                       coproc_load_allowed,
	output logic                       standalone,
	output logic                       eeprom_load_en,
	output logic                       usb_load_en,
	output logic                       debug_uart_en,
	output logic                       first_dual_role_port_host,
	output logic                       other_ports_peripheral,
	output logic      [GPIO_WIDTH-1:0] gpio_oe,
	output logic      [GPIO_WIDTH-1:0] strap_pins_released
);
	boot_state_t state;
	boot_state_t next_state;
	logic [1:0]  next_boot_mode;
	logic        next_clock_is_12mhz;
	logic        next_fw_from_usb;
	logic        fw_from_usb;
	logic        first_cycle;
	logic        timer_done;
	logic        dual_role_id_input;

	// Boot window timing lives in its own counter
	boot_timer #(
		.CYCLES (BOOT_COUNT)
	) u_timer (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.start   (first_cycle),
		.done    (timer_done)
	);

	assign dual_role_id_input = gpio_in[ID_POS];
	assign first_cycle        = (state == ST_IDLE);

	// Straps are caught at the first clocked edge after release, not by reset itself
	always_comb
	begin
		next_state          = state;
		next_boot_mode      = boot_mode;
		next_clock_is_12mhz = clock_is_12mhz;
		next_fw_from_usb    = fw_from_usb;
		unique case (state)
			ST_IDLE:
			begin
				next_boot_mode      = {gpio_in[STRAP_HI_POS], gpio_in[STRAP_LO_POS]}; // [R1] [R2]
				next_clock_is_12mhz = (clock_source_strap == CLK_SEL_12MHZ); // [R16]
				next_state          = ST_BOOT; // [R3]
			end
			ST_BOOT:
			begin
				// Mode is frozen; strap pins are no longer looked at
				if (timer_done) // [R3] [R6]
					next_state = (boot_mode == MODE_ALONE) ? ST_ALONE : ST_COPROC;
			end
			ST_COPROC:
				next_state = ST_COPROC; // [R17]
			ST_ALONE:
			begin
				// USB loading may replace EEPROM loading until EEPROM finishes
				if (usb_load_req && !eeprom_load_done)
					next_fw_from_usb = 1'b1; // [R15]
			end
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			state          <= ST_IDLE;
			boot_mode      <= MODE_RESET;
			clock_is_12mhz <= 1'b0;
			fw_from_usb    <= 1'b0;
		end
		else
		begin
			state          <= next_state;
			boot_mode      <= next_boot_mode; // [R17]
			clock_is_12mhz <= next_clock_is_12mhz; // [R17]
			fw_from_usb    <= next_fw_from_usb;
		end
	end

	// Status follows the boot state; interface enables follow state and latched mode
	assign boot_busy   = (state == ST_IDLE) || (state == ST_BOOT);
	assign boot_done   = (state == ST_COPROC) || (state == ST_ALONE);
	assign standalone  = (state == ST_ALONE);
	assign parallel_host_port_en = (state == ST_COPROC) && (boot_mode == MODE_PARALLEL); // [R5] [R7]
	assign fast_serial_port_en   = (state == ST_COPROC) && (boot_mode == MODE_SERIAL); // [R5] [R9]
	assign spi_slave_en          = (state == ST_COPROC) && (boot_mode == MODE_SPI); // [R5] [R8]
	assign coproc_load_allowed   = (state == ST_COPROC); // [R6]

	// Standalone pin setup; all other pins stay inputs
	assign eeprom_load_en  = standalone && !fw_from_usb && !eeprom_load_done; // [R15]
	assign usb_load_en     = standalone && fw_from_usb; // [R15]
	assign debug_uart_en   = standalone; // [R11]
	assign first_dual_role_port_host = standalone && !dual_role_id_input; // [R12]
	assign other_ports_peripheral    = standalone; // [R13]

	always_comb
	begin
		gpio_oe = {GPIO_WIDTH{1'b0}}; // [R14]
		if (standalone)
		begin
			gpio_oe[STRAP_HI_POS] = 1'b1; // [R10]
			gpio_oe[STRAP_LO_POS] = 1'b1; // [R10]
			gpio_oe[UART_A_POS]   = 1'b1; // [R11]
		end
	end

	// Strap pins handed to the application once boot ends, except in standalone
	always_comb
	begin
		strap_pins_released = {GPIO_WIDTH{1'b0}};
		if (state == ST_COPROC)
		begin
			strap_pins_released[STRAP_HI_POS] = 1'b1; // [R4]
			strap_pins_released[STRAP_LO_POS] = 1'b1; // [R4]
		end
	end
endmodule : boot_strap_mode_select

// *** rtl/boot_timer.sv ***
// Down counter that flags the end of the boot procedure window
`timescale 1ns/1ps
module boot_timer
	import boot_strap_pkg::*;
#(
	parameter int unsigned CYCLES = BOOT_CYCLES
)
(
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic start,
	output logic      done
);
	logic [31:0] count;
	logic [31:0] next_count;
	logic        next_done;

	// Reload on start, count to zero, then raise done for one cycle
	always_comb
	begin
		next_count = count;
		next_done  = 1'b0;
		if (start)
			next_count = 32'(CYCLES - 1);
		else if (count != 32'h0)
		begin
			next_count = count - 32'h1;
			next_done  = (count == 32'h1);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			count <= 32'h0;
			done  <= 1'b0;
		end
		else
		begin
			count <= next_count;
			done  <= next_done;
		end
	end
endmodule : boot_timer

// *** shared/boot_strap_pkg.sv ***
// Package with boot strap constants, mode encodings and timing counts
// Behaviour
// [R1] Boot mode is taken from the two strap pins when reset is released.
// [R2] Straps upper,lower: 00 parallel host, 01 fast serial, 10 SPI slave, 11 standalone.
// [R3] Built-in boot procedure runs after reset and finishes within 3 ms.
// [R4] Straps sampled only during boot, then released as ordinary pins; the code releases them only in the coprocessor modes.
// [R5] Coprocessor modes enable only the chosen interface and wait idle.
// [R6] Loading over coprocessor interface starts only after the 3 ms boot.
// [R7] External processor uses exactly one of the three interfaces.
// [R8] SPI slave path is kept at or below 2 Mb/s by the master.
// [R9] Fast serial path is kept at or below 2M baud by the processor.
// [R10] Standalone boot drives both strap pins as outputs to read the EEPROM.
// [R11] Standalone boot enables pins 28 and 27 as debug UART.
// [R12] Standalone boot uses pin 29 as ID: high peripheral, low host.
// [R13] Standalone boot sets the three other USB ports to peripheral.
// [R14] Standalone boot leaves every other pin as an input.
// [R15] Standalone internal processor loads firmware from EEPROM, or over USB.
// [R16] Clock-source strap sampled after reset; 12 MHz needed for normal use.
// [R17] Latched mode and clock selection hold until the next reset release; the code clears them to MODE_RESET and 0 while reset is asserted.
package boot_strap_pkg;
	localparam int unsigned CLK_HZ        = 200000000;
	localparam int unsigned BOOT_TIME_US  = 3000;
	localparam int unsigned BOOT_CYCLES   = (BOOT_TIME_US * (CLK_HZ / 1000000));
	localparam int unsigned GPIO_WIDTH    = 32;
	localparam int unsigned STRAP_HI_POS  = 31;
	localparam int unsigned STRAP_LO_POS  = 30;
	localparam int unsigned ID_POS        = 29;
	localparam int unsigned UART_A_POS    = 28;
	localparam int unsigned UART_B_POS    = 27;
	localparam logic [1:0]  MODE_PARALLEL = 2'h0;
	localparam logic [1:0]  MODE_SERIAL   = 2'h1;
	localparam logic [1:0]  MODE_SPI      = 2'h2;
	localparam logic [1:0]  MODE_ALONE    = 2'h3;
	localparam logic        CLK_SEL_12MHZ = 1'h1;
	localparam logic [1:0]  MODE_RESET    = 2'h0;
	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h1,
		ST_BOOT = 4'h2,
		ST_COPROC = 4'h4,
		ST_ALONE = 4'h8
	} boot_state_t;
endpackage : boot_strap_pkg

// *** sim/boot_strap_mode_select_properties.sv ***
// Concurrent checks on strap latching and post-boot pin roles
`timescale 1ns/1ps
module boot_strap_checker
	import boot_strap_pkg::*;
(
	input wire logic                  sys_clk,
	input wire logic                  nrst,
	input wire logic [GPIO_WIDTH-1:0] gpio_in,
	input wire logic [1:0]            boot_mode,
	input wire logic                  boot_busy,
	input wire logic                  boot_done,
	input wire logic                  parallel_host_port_en,
	input wire logic                  fast_serial_port_en,
	input wire logic                  spi_slave_en,
	input wire logic                  coproc_load_allowed,
	input wire logic                  standalone,
	input wire logic                  debug_uart_en,
	input wire logic                  first_dual_role_port_host,
	input wire logic [GPIO_WIDTH-1:0] gpio_oe,
	input wire logic [GPIO_WIDTH-1:0] strap_pins_released
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Latch, hold, then pin roles; roles depend on the latched mode, the host role also on the live ID pin
	mode_latch_a: assert property ($rose(nrst) |=> boot_mode == $past(gpio_in[31:30]))
		else $error("mode not latched");
	mode_hold_a: assert property (boot_done |=> $stable(boot_mode))
		else $error("mode moved");
	one_port_a: assert property (boot_done && boot_mode != MODE_ALONE |->
		{spi_slave_en, fast_serial_port_en, parallel_host_port_en} == 3'h1 << boot_mode) else $error("port enables");
	idle_ports_a: assert property (boot_busy |-> gpio_oe == 32'h0 &&
		!(parallel_host_port_en | fast_serial_port_en | spi_slave_en | coproc_load_allowed | standalone))
		else $error("active while busy");
	alone_pins_a: assert property (standalone |-> gpio_oe == 32'hd0000000 && debug_uart_en)
		else $error("standalone pins");
	id_role_a: assert property (standalone |-> first_dual_role_port_host == !gpio_in[ID_POS])
		else $error("id role");
	strap_free_a: assert property (strap_pins_released == (boot_done && !standalone ? 32'hc0000000 : 32'h0))
		else $error("strap release");
	alone_flag_a: assert property (standalone == (boot_done && boot_mode == MODE_ALONE))
		else $error("standalone flag");
endmodule : boot_strap_checker

bind boot_strap_mode_select boot_strap_checker chk_i (.*);

// *** sim/eeprom_model.sv ***
// Serial boot memory stand-in that reports a finished load
`timescale 1ns/1ps
module eeprom_model
(
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic load_en,
	output logic      load_done
);
	logic [2:0] cnt;
	// Short copy; done stays high until reset like a real finished load
	always @(posedge sys_clk)
	begin
		cnt <= (!nrst || !load_en) ? 3'h0 : cnt + 3'h1;
		load_done <= nrst && (load_done || cnt == 3'h5);
	end
endmodule : eeprom_model

// *** sim/tb_top.sv ***
// Random boot strap bench, all four modes forced first
`timescale 1ns/1ps
module tb_top import boot_strap_pkg::*;;
	localparam int BC = 8;
	logic sys_clk = 1'h0, nrst = 1'h0, clock_source_strap = 1'h0, usb_load_req = 1'h0;
	logic [31:0] gpio_in = 32'h0;
	logic eeprom_load_done, clock_is_12mhz, boot_busy, boot_done, parallel_host_port_en, fast_serial_port_en;
	logic spi_slave_en, coproc_load_allowed, standalone, eeprom_load_en, usb_load_en, debug_uart_en;
	logic first_dual_role_port_host, other_ports_peripheral, c, q;
	logic [1:0] boot_mode, m;
	logic [31:0] gpio_oe, strap_pins_released;
	int n_fail = 0, compares = 0, n;
	always #2.5 sys_clk = ~sys_clk;
	boot_strap_mode_select #(.BOOT_COUNT(BC)) DUT (.*);
	eeprom_model EE (.sys_clk, .nrst, .load_en(eeprom_load_en), .load_done(eeprom_load_done));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic close_out();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	function automatic logic [2:0] exp_en(input logic [1:0] md);
		return (md == MODE_ALONE) ? 3'h0 : 3'h1 << md;
	endfunction : exp_en
	// Each test: reset with straps set, scramble straps after sampling, check roles
	initial
	begin
		void'($urandom(32'h0f56fe94));
		for (int t = 0; t < 12; t++)
		begin
			@(negedge sys_clk);
			nrst = 1'h0;
			m = (t < 4) ? 2'(t) : 2'($urandom);
			c = 1'($urandom);
			q = 1'($urandom);
			gpio_in = {m, 30'($urandom)};
			clock_source_strap = c;
			usb_load_req = q;
			repeat (5) @(negedge sys_clk);
			nrst = 1'h1;
			@(negedge sys_clk);
			gpio_in = $urandom;
			clock_source_strap = ~c;
			n = 0;
			while (boot_done !== 1'h1 && n < 40)
			begin
				@(negedge sys_clk);
				n++;
			end
			chk("boot_time", 32'h1, 32'(n >= BC && n <= BC + 2));
			if (n == 40)
				close_out();
			chk("mode", m, boot_mode);
			chk("clock", c, clock_is_12mhz);
			chk("ports", exp_en(m), {spi_slave_en, fast_serial_port_en, parallel_host_port_en});
			chk("load_ok", m != MODE_ALONE, coproc_load_allowed);
			chk("oe", (m == MODE_ALONE) ? 32'hd0000000 : 32'h0, gpio_oe);
			chk("roles", {3{m == MODE_ALONE}}, {standalone, debug_uart_en, other_ports_peripheral});
			// USB choice is registered one cycle after standalone starts
			@(negedge sys_clk);
			chk("loader", {m == MODE_ALONE && q, m == MODE_ALONE && !q}, {usb_load_en, eeprom_load_en});
			repeat (10) @(negedge sys_clk);
			chk("ee_after", 32'h0, eeprom_load_en);
			$display("test %0d mode %0d end", t, m);
		end
		close_out();
	end
endmodule : tb_top
